// >>> inc/bridge_regs_pkg.sv
package bridge_regs_pkg;
  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DATA2 = 8'h4d;
  localparam logic [7:0] IDX_DATA3 = 8'h4e;
  localparam logic [7:0] IDX_CTRL = 8'h4f;
  localparam logic [7:0] IDX_STATUS = 8'h50;
  localparam logic [7:0] IDX_TARGET = 8'h51;
  localparam logic [7:0] IDX_TIMING = 8'h52;
  localparam logic [7:0] IDX_OUTDLY = 8'h53;
  localparam logic [7:0] IDX_WIN_CTRL = 8'h60;
  localparam logic [7:0] IDX_WIN_ADDR = 8'h61;
  localparam logic [7:0] IDX_WIN_DLO = 8'h62;
  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int CTL_CEC_SRC = 4;
  localparam int CTL_CEC_EN = 3;
  localparam int CTL_ERASE = 2;
  localparam int CTL_RELOAD = 1;
  localparam int CTL_BLOCK = 0;
  localparam int WIN_START = 0;
  localparam int WIN_INC = 1;
  localparam int WIN_SEL_LO = 2;
  // ----------------------------------------------------------------
  // Values after reset and window address steps.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [6:0] RST_TARGET = 7'h28;
  localparam logic [2:0] RST_HOLD = 3'h1;
  localparam logic [3:0] RST_FILTER = 4'he;
  localparam logic [1:0] RST_OUTDLY = 2'h0;
  localparam logic [1:0] SEL_RECEIVER = 2'h0;
  localparam logic [15:0] INC_RECEIVER = 16'h0004;
  localparam logic [15:0] INC_OTHER = 16'h0001;
  // ----------------------------------------------------------------
  // Clock rates, cycle counts and timing steps in ns.
  // ----------------------------------------------------------------
  localparam int CORE_HZ = 40000000;
  localparam int OSC_HZ = 25000000;
  localparam int CEC_HZ = 32768;
  localparam int CEC_INT_HALF = CORE_HZ / (2 * CEC_HZ);
  localparam int CEC_EXT_HALF = OSC_HZ / (2 * CEC_HZ);
  localparam int HOLD_STEP_NS = 40;
  localparam int FILTER_STEP_NS = 5;
  localparam int OUTDLY_STEP_NS = 40;
  localparam int OUTDLY_BASE_NS = 240;
endpackage

// >>> src/bridge_control_status_display_id.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bridge_control_status_display_id (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Pins.
  input wire logic mode_strap_pin_first_in,
  input wire logic receive_supply_sense_pin_in,
  input wire logic osc_25mhz_in,
  // Receiver and init engine.
  input wire logic receiver_irq_in,
  input wire logic config_done_in,
  input wire logic config_cksum_ok_in,
  input wire logic init_done_in,
  input wire logic remote_loaded_in,
  input wire logic reload_done_in,
  input wire logic id_cksum_ok_in,
  // Indirect window read.
  output logic window_rd_req_out,
  output logic [15:0] window_addr_out,
  output logic [1:0] window_sel_out,
  input wire logic window_rd_ack_in,
  input wire logic [31:0] window_rd_data_in,
  // DDC target request.
  input wire logic ddc_req_in,
  input wire logic [6:0] ddc_addr_in,
  input wire logic ddc_write_in,
  output logic ddc_ack_out,
  output logic ddc_sram_we_out,
  // Controls to the rest of the device.
  output logic cec_clk_out,
  output logic id_sram_reload_out,
  output logic id_sram_erase_out,
  output logic ddc_id_access_block_out,
  output logic [6:0] id_target_addr_out,
  output logic id_sram_write_protect_out,
  output logic [2:0] ddc_data_hold_time_out,
  output logic [3:0] ddc_glitch_filter_depth_out,
  output logic [1:0] ddc_data_output_delay_out
);
  import bridge_regs_pkg::*;

  typedef struct packed {
    logic [7:0] data2;
    logic [7:0] data3;
    logic cec_src;
    logic cec_en;
    logic erase;
    logic reload;
    logic block;
    logic [6:0] target;
    logic wprot;
    logic [2:0] hold;
    logic [3:0] filt;
    logic [1:0] odly;
    logic cfg_done;
    logic init_done;
    logic rem_loaded;
    logic cfg_ok;
    logic id_ok;
    logic [2:0] rx5_s;
    logic rx5_lvl;
    logic [2:0] strap_s;
    logic strap_taken;
    logic [2:0] strap_v;
    logic [2:0] osc_s;
    logic osc_lvl;
    logic [9:0] cec_cnt;
    logic cec_clk;
    logic win_start;
    logic win_inc;
    logic [1:0] win_sel;
    logic [15:0] win_addr;
    logic [15:0] win_dlo;
    logic ddc_ack;
    logic ddc_we;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [7:0] idx;
  logic access;
  logic wr_now;
  logic osc_rise;
  logic [9:0] half;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------

  // Two flops release the asynchronous reset cleanly.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // Tells whether an index names a register of this block.
  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      IDX_DATA2, IDX_DATA3, IDX_CTRL, IDX_STATUS, IDX_TARGET,
      IDX_TIMING, IDX_OUTDLY, IDX_WIN_CTRL, IDX_WIN_ADDR,
      IDX_WIN_DLO: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Read value of a register; reserved bits read zero.
  function automatic logic [31:0] rd_val(input state_t s,
                                         input logic [7:0] i,
                                         input logic irq);
    case (i)
      IDX_DATA2: rd_val = {24'h0, s.data2};
      IDX_DATA3: rd_val = {24'h0, s.data3};
      IDX_CTRL: rd_val = {27'h0, s.cec_src, s.cec_en, s.erase,
                          s.reload, s.block};
      IDX_STATUS: rd_val = {24'h0, s.rx5_lvl, irq, 1'b0, s.init_done,
                            s.rem_loaded, s.cfg_done, s.cfg_ok,
                            s.id_ok};
      IDX_TARGET: rd_val = {24'h0, s.target, s.wprot};
      IDX_TIMING: rd_val = {24'h0, 1'b0, s.hold, s.filt};
      IDX_OUTDLY: rd_val = {30'h0, s.odly};
      IDX_WIN_CTRL: rd_val = {28'h0, s.win_sel, s.win_inc,
                              s.win_start};
      IDX_WIN_ADDR: rd_val = {16'h0, s.win_addr};
      IDX_WIN_DLO: rd_val = {16'h0, s.win_dlo};
      default: rd_val = 32'h0;
    endcase
  endfunction

  assign idx = paddr_in[9:2];
  assign access = psel_in && penable_in;
  assign wr_now = access && state_r.pready && pwrite_in &&
                  !state_r.pslverr;
  assign osc_rise = state_r.osc_s[1] && state_r.osc_s[2] &&
                    !state_r.osc_lvl;
  assign half = state_r.cec_src ? 10'(CEC_EXT_HALF - 1) :
                10'(CEC_INT_HALF - 1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Computes the whole next state of the block.
  always_comb begin
    state_nxt = state_r;
    // Pins pass three flops; a level counts once stages two and three agree.
    state_nxt.rx5_s = {state_r.rx5_s[1:0], receive_supply_sense_pin_in};
    state_nxt.strap_s = {state_r.strap_s[1:0], mode_strap_pin_first_in};
    state_nxt.osc_s = {state_r.osc_s[1:0], osc_25mhz_in};
    state_nxt.strap_v = {state_r.strap_v[1:0], 1'b1};
    if (state_r.rx5_s[1] == state_r.rx5_s[2]) begin
      state_nxt.rx5_lvl = state_r.rx5_s[2];
    end
    if (state_r.osc_s[1] == state_r.osc_s[2]) begin
      state_nxt.osc_lvl = state_r.osc_s[2];
    end
    // The strap is caught once its three stages hold real pin samples.
    if (!state_r.strap_taken && state_r.strap_v[2] &&
        state_r.strap_s[1] == state_r.strap_s[2]) begin
      state_nxt.strap_taken = 1'b1;
      state_nxt.block = state_r.strap_s[2];
    end

    // CEC divider counts core cycles or oscillator edges.
    // Only oscillator rises that the pin filter resolves are counted.
    if (!state_r.cec_en) begin
      state_nxt.cec_cnt = 10'h0;
      state_nxt.cec_clk = 1'b0;
    end else if (state_r.cec_src ? osc_rise : 1'b1) begin
      if (state_r.cec_cnt >= half) begin
        state_nxt.cec_cnt = 10'h0;
        state_nxt.cec_clk = !state_r.cec_clk;
      end else begin
        state_nxt.cec_cnt = state_r.cec_cnt + 10'h1;
      end
    end

    // APB answers one cycle into the access phase.
    state_nxt.pready = 1'b0;
    if (access && !state_r.pready) begin
      state_nxt.pready = 1'b1;
      state_nxt.pslverr = !is_mapped(idx) || (paddr_in[1:0] != 2'b00) ||
                          (paddr_in[11:10] != 2'b00);
      state_nxt.prdata = pwrite_in ? 32'h0 :
                         rd_val(state_r, idx, receiver_irq_in);
    end

    // Register writes; read-only and reserved bits are dropped.
    if (wr_now) begin
      case (idx)
        IDX_DATA2: state_nxt.data2 = pwdata_in[7:0];
        IDX_DATA3: state_nxt.data3 = pwdata_in[7:0];
        IDX_CTRL: begin
          state_nxt.cec_src = pwdata_in[CTL_CEC_SRC];
          state_nxt.cec_en = pwdata_in[CTL_CEC_EN];
          if (pwdata_in[CTL_RELOAD] && !state_r.reload) begin
            state_nxt.reload = 1'b1;
            state_nxt.erase = pwdata_in[CTL_ERASE];
            state_nxt.id_ok = 1'b0;
          end
        end
        IDX_TARGET: begin
          state_nxt.target = pwdata_in[7:1];
          state_nxt.wprot = pwdata_in[0];
        end
        IDX_TIMING: begin
          state_nxt.hold = pwdata_in[6:4];
          state_nxt.filt = pwdata_in[3:0];
        end
        IDX_OUTDLY: state_nxt.odly = pwdata_in[1:0];
        IDX_WIN_CTRL: begin
          state_nxt.win_inc = pwdata_in[WIN_INC];
          state_nxt.win_sel = pwdata_in[WIN_SEL_LO +: 2];
          if (pwdata_in[WIN_START]) begin
            state_nxt.win_start = 1'b1;
          end
        end
        IDX_WIN_ADDR: state_nxt.win_addr = pwdata_in[15:0];
        default: begin
        end
      endcase
    end

    // A finished window read fills the data bytes and may step the address.
    if (state_r.win_start && window_rd_ack_in) begin
      state_nxt.win_start = 1'b0;
      state_nxt.win_dlo = window_rd_data_in[15:0];
      state_nxt.data2 = window_rd_data_in[23:16];
      state_nxt.data3 = window_rd_data_in[31:24];
      if (state_r.win_inc) begin
        state_nxt.win_addr = state_r.win_addr +
          ((state_r.win_sel == SEL_RECEIVER) ? INC_RECEIVER : INC_OTHER);
      end
    end

    // Reload end clears both request bits.
    if (reload_done_in && state_r.reload) begin
      state_nxt.reload = 1'b0;
      state_nxt.erase = 1'b0;
      state_nxt.id_ok = id_cksum_ok_in;
    end

    // Status flags from the init engine; the done flags are sticky, the checksum flags follow each event.
    if (config_done_in) begin
      state_nxt.cfg_done = 1'b1;
      state_nxt.cfg_ok = config_cksum_ok_in;
    end
    if (init_done_in && (state_r.cfg_done || config_done_in)) begin
      state_nxt.init_done = 1'b1;
    end
    if (remote_loaded_in) begin
      state_nxt.rem_loaded = 1'b1;
      state_nxt.id_ok = id_cksum_ok_in;
    end

    // DDC target answers only a matching, unblocked address.
    state_nxt.ddc_ack = ddc_req_in && !state_r.block &&
                        (ddc_addr_in == state_r.target);
    state_nxt.ddc_we = state_nxt.ddc_ack && ddc_write_in &&
                       !state_r.wprot;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Registers the whole state with its reset values.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
      state_r.data2 <= RST_DATA;
      state_r.data3 <= RST_DATA;
      state_r.target <= RST_TARGET;
      state_r.hold <= RST_HOLD;
      state_r.filt <= RST_FILTER;
      state_r.odly <= RST_OUTDLY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs come straight from the state flops.
  assign prdata_out = state_r.prdata;
  assign pready_out = state_r.pready;
  assign pslverr_out = state_r.pslverr;
  assign window_rd_req_out = state_r.win_start;
  assign window_addr_out = state_r.win_addr;
  assign window_sel_out = state_r.win_sel;
  assign ddc_ack_out = state_r.ddc_ack;
  assign ddc_sram_we_out = state_r.ddc_we;
  assign cec_clk_out = state_r.cec_clk;
  assign id_sram_reload_out = state_r.reload;
  assign id_sram_erase_out = state_r.erase;
  assign ddc_id_access_block_out = state_r.block;
  assign id_target_addr_out = state_r.target;
  assign id_sram_write_protect_out = state_r.wprot;
  assign ddc_data_hold_time_out = state_r.hold;
  assign ddc_glitch_filter_depth_out = state_r.filt;
  assign ddc_data_output_delay_out = state_r.odly;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  property p_cec_off;
    @(posedge clk_in) disable iff (!rst_n)
      !state_r.cec_en |=> !cec_clk_out;
  endproperty
  a_cec_off: assert property (p_cec_off)
    else $error("CEC clock runs while disabled.");

  property p_cec_int;
    @(posedge clk_in) disable iff (!rst_n)
      (state_r.cec_en && !state_r.cec_src && $rose(cec_clk_out)) ##1
      (state_r.cec_en && !state_r.cec_src)[*8] |-> cec_clk_out;
  endproperty
  a_cec_int: assert property (p_cec_int)
    else $error("Internal CEC half period too short.");

  property p_erase_pair;
    @(posedge clk_in) disable iff (!rst_n)
      $rose(id_sram_erase_out) |-> $rose(id_sram_reload_out);
  endproperty
  a_erase_pair: assert property (p_erase_pair)
    else $error("Erase started without reload.");

  property p_reload_end;
    @(posedge clk_in) disable iff (!rst_n)
      (id_sram_reload_out && reload_done_in) |=>
      (!id_sram_reload_out && !id_sram_erase_out);
  endproperty
  a_reload_end: assert property (p_reload_end)
    else $error("Reload bits did not clear on completion.");

  property p_block_ack;
    @(posedge clk_in) disable iff (!rst_n)
      ddc_ack_out |-> !$past(state_r.block) &&
      ($past(ddc_addr_in) == $past(state_r.target));
  endproperty
  a_block_ack: assert property (p_block_ack)
    else $error("DDC acknowledged a blocked or foreign address.");

  property p_wprot;
    @(posedge clk_in) disable iff (!rst_n)
      ddc_sram_we_out |-> ddc_ack_out && !$past(state_r.wprot);
  endproperty
  a_wprot: assert property (p_wprot)
    else $error("Protected SRAM was written over DDC.");

  property p_init_order;
    @(posedge clk_in) disable iff (!rst_n)
      $rose(state_r.init_done) |-> state_r.cfg_done;
  endproperty
  a_init_order: assert property (p_init_order)
    else $error("Init done raised before configuration done.");

  property p_win_done;
    @(posedge clk_in) disable iff (!rst_n)
      (window_rd_req_out && window_rd_ack_in) |=>
      (!window_rd_req_out &&
       {state_r.data3, state_r.data2} == $past(window_rd_data_in[31:16]));
  endproperty
  a_win_done: assert property (p_win_done)
    else $error("Window read result not stored.");

  property p_win_inc;
    @(posedge clk_in) disable iff (!rst_n)
      (window_rd_req_out && window_rd_ack_in && state_r.win_inc &&
       window_sel_out == SEL_RECEIVER && !wr_now) |=>
      window_addr_out == $past(window_addr_out) + INC_RECEIVER;
  endproperty
  a_win_inc: assert property (p_win_inc)
    else $error("Receiver window address did not step by four.");

  property p_apb_wait;
    @(posedge clk_in) disable iff (!rst_n)
      (psel_in && !penable_in) ##1 (psel_in && penable_in) |=>
      pready_out;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("APB answer missing one cycle into access.");
endmodule
`default_nettype wire

// >>> testbench/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  // Clock.
  input wire logic clk_in,
  // Video source on the DDC target port.
  output logic ddc_req_out,
  output logic [6:0] ddc_addr_out,
  output logic ddc_write_out,
  input wire logic ddc_ack_in,
  input wire logic ddc_sram_we_in,
  // Receiver side of the indirect window.
  input wire logic window_rd_req_in,
  output logic window_rd_ack_out,
  output logic [31:0] window_rd_data_out,
  input wire logic [3:0] delay_in,
  input wire logic [31:0] word_in
);
  // -------------------------------------------------------------
  // DDC access from the video source.
  // -------------------------------------------------------------
  // One request cycle, then the answer cycle is sampled.
  task access(input logic [6:0] a, input logic wr, output logic ack,
              output logic we);
    @(posedge clk_in);
    ddc_req_out <= 1'h1;
    ddc_addr_out <= a;
    ddc_write_out <= wr;
    @(posedge clk_in);
    ddc_req_out <= 1'h0;
    ddc_addr_out <= ~a;
    ddc_write_out <= ~wr;
    @(posedge clk_in);
    ack = ddc_ack_in;
    we = ddc_sram_we_in;
  endtask
  // -------------------------------------------------------------
  // Window read responder.
  // -------------------------------------------------------------
  // Answers after a programmable wait; data is scrambled outside it.
  initial begin
    ddc_req_out = 1'h0;
    ddc_addr_out = 7'h00;
    ddc_write_out = 1'h0;
    window_rd_ack_out = 1'h0;
    window_rd_data_out = 32'h0;
    forever begin
      @(posedge clk_in);
      if (window_rd_req_in === 1'h1) begin
        repeat (delay_in) @(posedge clk_in);
        window_rd_ack_out <= 1'h1;
        window_rd_data_out <= word_in;
        @(posedge clk_in);
        window_rd_ack_out <= 1'h0;
        window_rd_data_out <= ~word_in;
        @(posedge clk_in);
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bridge_regs_pkg::*;
  logic clk_in = 1'h0, osc = 1'h0, osc_run = 1'h1, arst_n_in = 1'h0;
  logic psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdat, win_data;
  logic [31:0] win_word = 32'hdeadbeef;
  logic pready_out, pslverr_out, rerr, strap = 1'h0, sup = 1'h0;
  logic irq = 1'h0, cfg_done = 1'h0, init_done = 1'h0, rem_ld = 1'h0;
  logic rl_done = 1'h0, ok = 1'h0, win_req, win_ack, ddc_req, ddc_wr;
  logic ddc_ack, ddc_we, cec, rl_o, er_o, blk_o, wp_o;
  logic [15:0] win_addr;
  logic [1:0] win_sel, dly_o;
  logic [6:0] ddc_addr, tgt_o;
  logic [2:0] hold_o;
  logic [3:0] flt_o, win_delay = 4'h3;
  int num_errors = 0, tests_run = 0;
  // Device under test.
  bridge_control_status_display_id dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .mode_strap_pin_first_in(strap), .receive_supply_sense_pin_in(sup),
    .osc_25mhz_in(osc), .receiver_irq_in(irq), .config_done_in(cfg_done),
    .config_cksum_ok_in(ok), .init_done_in(init_done),
    .remote_loaded_in(rem_ld), .reload_done_in(rl_done),
    .id_cksum_ok_in(ok), .window_rd_req_out(win_req),
    .window_addr_out(win_addr), .window_sel_out(win_sel),
    .window_rd_ack_in(win_ack), .window_rd_data_in(win_data),
    .ddc_req_in(ddc_req), .ddc_addr_in(ddc_addr), .ddc_write_in(ddc_wr),
    .ddc_ack_out(ddc_ack), .ddc_sram_we_out(ddc_we), .cec_clk_out(cec),
    .id_sram_reload_out(rl_o), .id_sram_erase_out(er_o),
    .ddc_id_access_block_out(blk_o), .id_target_addr_out(tgt_o),
    .id_sram_write_protect_out(wp_o), .ddc_data_hold_time_out(hold_o),
    .ddc_glitch_filter_depth_out(flt_o), .ddc_data_output_delay_out(dly_o));
  // Far side: video source and window responder.
  far_side_model src (.clk_in(clk_in), .ddc_req_out(ddc_req),
    .ddc_addr_out(ddc_addr), .ddc_write_out(ddc_wr), .ddc_ack_in(ddc_ack),
    .ddc_sram_we_in(ddc_we), .window_rd_req_in(win_req),
    .window_rd_ack_out(win_ack), .window_rd_data_out(win_data),
    .delay_in(win_delay), .word_in(win_word));
  // -------------------------------------------------------------
  // Clocks and shared tasks.
  // -------------------------------------------------------------
  // Core clock at 40 MHz and a stoppable oscillator model.
  initial forever #12.5 clk_in = ~clk_in;
  // The model rises every 8 core cycles so the pin filter sees each rise.
  initial forever begin
    #100;
    if (osc_run) osc = ~osc;
  end
  // Compares and counts.
  task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, seen);
    end
  endtask
  // One APB transfer; waits for pready without assuming a latency.
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk_in);
    psel_in <= 1'h1;
    pwrite_in <= wr;
    paddr_in <= {2'h0, idx, 2'h0};
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 40);
    if (pready_out !== 1'h1) num_errors++;
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task rd_chk(input logic [7:0] idx, input logic [31:0] e);
    apb(1'h0, idx, 32'h0);
    check($sformatf("reg %h", idx), rdat, e);
  endtask
  // Pulses engine events: init, config, remote load, reload done.
  task strobe(input logic [3:0] m, input logic k);
    @(posedge clk_in);
    {init_done, cfg_done, rem_ld, rl_done} <= m;
    ok <= k;
    @(posedge clk_in);
    {init_done, cfg_done, rem_ld, rl_done} <= 4'h0;
    ok <= 1'h0;
    repeat (2) @(posedge clk_in);
  endtask
  task ddc(input logic [6:0] a, input logic wr, input logic [1:0] e);
    logic ack, we;
    src.access(a, wr, ack, we);
    check("ddc ack and write", {ack, we}, e);
  endtask
  task do_reset(input logic s);
    @(posedge clk_in);
    arst_n_in <= 1'h0;
    strap <= s;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'h1;
    repeat (8) @(posedge clk_in);
  endtask
  // Counts the high time of the next CEC clock pulse, 0 if none.
  task cec_high(output int n);
    int w;
    w = 0;
    n = 0;
    while (cec !== 1'h1 && w < 7000) begin
      @(posedge clk_in);
      w++;
    end
    while (cec === 1'h1 && n < 7000) begin
      @(posedge clk_in);
      n++;
    end
  endtask
  task win_wait();
    int n;
    n = 0;
    @(posedge clk_in);
    while (win_req !== 1'h0 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 100) num_errors++;
  endtask
  // -------------------------------------------------------------
  // Scenarios.
  // -------------------------------------------------------------
  task t_defaults();
    rd_chk(IDX_DATA3, 32'h0);
    rd_chk(IDX_CTRL, 32'h0);
    rd_chk(IDX_STATUS, 32'h0);
    rd_chk(IDX_TARGET, 32'h50);
    rd_chk(IDX_TIMING, 32'h1e);
    rd_chk(IDX_OUTDLY, 32'h0);
    check("hold filt", {hold_o, flt_o}, 7'h1e);
    check("dly tgt wp", {dly_o, tgt_o, wp_o}, 10'h050);
  endtask
  task t_regs();
    apb(1'h1, IDX_DATA2, 32'ha5);
    apb(1'h1, IDX_DATA3, 32'h5a);
    rd_chk(IDX_DATA2, 32'ha5);
    rd_chk(IDX_DATA3, 32'h5a);
    apb(1'h1, IDX_TIMING, 32'hff);
    apb(1'h1, IDX_OUTDLY, 32'hff);
    rd_chk(IDX_TIMING, 32'h7f);
    rd_chk(IDX_OUTDLY, 32'h03);
    check("fields", {hold_o, flt_o, dly_o}, 9'h1ff);
    apb(1'h1, IDX_STATUS, 32'hff);
    apb(1'h1, IDX_CTRL, 32'he1);
    rd_chk(IDX_STATUS, 32'h0);
    rd_chk(IDX_CTRL, 32'h0);
    apb(1'h1, 8'h70, 32'h1);
    check("write error", rerr, 1'h1);
    rd_chk(8'h70, 32'h0);
  endtask
  task t_reload();
    apb(1'h1, IDX_CTRL, 32'h04);
    @(posedge clk_in);
    check("erase alone", {er_o, rl_o}, 2'h0);
    apb(1'h1, IDX_CTRL, 32'h06);
    @(posedge clk_in);
    check("erase reload", {er_o, rl_o}, 2'h3);
    rd_chk(IDX_CTRL, 32'h06);
    strobe(4'h1, 1'h1);
    check("reload done", {er_o, rl_o}, 2'h0);
    rd_chk(IDX_CTRL, 32'h0);
    rd_chk(IDX_STATUS, 32'h01);
  endtask
  task t_status();
    strobe(4'h8, 1'h0);
    rd_chk(IDX_STATUS, 32'h01);
    strobe(4'h4, 1'h1);
    rd_chk(IDX_STATUS, 32'h07);
    strobe(4'h8, 1'h0);
    rd_chk(IDX_STATUS, 32'h17);
    strobe(4'h2, 1'h1);
    rd_chk(IDX_STATUS, 32'h1f);
    sup <= 1'h1;
    irq <= 1'h1;
    repeat (6) @(posedge clk_in);
    rd_chk(IDX_STATUS, 32'hdf);
    irq <= 1'h0;
    rd_chk(IDX_STATUS, 32'h9f);
  endtask
  task t_ddc();
    ddc(7'h28, 1'h1, 2'h3);
    ddc(7'h28, 1'h0, 2'h2);
    ddc(7'h29, 1'h1, 2'h0);
    apb(1'h1, IDX_TARGET, 32'h61);
    rd_chk(IDX_TARGET, 32'h61);
    ddc(7'h30, 1'h1, 2'h2);
    ddc(7'h28, 1'h0, 2'h0);
  endtask
  task t_window();
    apb(1'h1, IDX_WIN_ADDR, 32'h10);
    apb(1'h1, IDX_WIN_CTRL, 32'h03);
    win_wait();
    rd_chk(IDX_DATA3, 32'hde);
    rd_chk(IDX_DATA2, 32'had);
    rd_chk(IDX_WIN_DLO, 32'hbeef);
    rd_chk(IDX_WIN_CTRL, 32'h02);
    check("addr", win_addr, 16'h0014);
    win_delay <= 4'h0;
    win_word <= 32'h12345678;
    apb(1'h1, IDX_WIN_CTRL, 32'h0b);
    win_wait();
    check("addr sel", {win_sel, win_addr}, 18'h20015);
    rd_chk(IDX_DATA3, 32'h12);
  endtask
  task t_cec();
    int n;
    apb(1'h1, IDX_CTRL, 32'h08);
    cec_high(n);
    check("cec internal", n > 608 && n < 612, 1'h1);
    apb(1'h1, IDX_CTRL, 32'h00);
    repeat (2) @(posedge clk_in);
    cec_high(n);
    check("cec off", n, 32'h0);
    osc_run = 1'h0;
    apb(1'h1, IDX_CTRL, 32'h18);
    cec_high(n);
    check("cec osc stopped", n, 32'h0);
    osc_run = 1'h1;
    cec_high(n);
    // 381 model rises of 8 core cycles each make one half period.
    check("cec osc", n > 3044 && n < 3052, 1'h1);
  endtask
  task t_strap();
    do_reset(1'h1);
    rd_chk(IDX_CTRL, 32'h01);
    rd_chk(IDX_DATA3, 32'h0);
    check("block", blk_o, 1'h1);
    ddc(7'h28, 1'h0, 2'h0);
  endtask
  // -------------------------------------------------------------
  // Sequence, verdict and watchdog.
  // -------------------------------------------------------------
  task wrap_up();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Runs every scenario in turn.
  initial begin
    do_reset(1'h0);
    t_defaults();
    t_regs();
    t_reload();
    t_status();
    t_ddc();
    t_window();
    t_cec();
    t_strap();
    wrap_up();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #1500000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
